// [common/scp_pkg.sv]
// constants and types for the serial control port with readback
package scp_pkg;

  localparam logic [6:0] SCP_RB_CTRL_ADDR  = 7'h34;
  localparam logic [6:0] SCP_SW_RESET_ADDR = 7'h35;
  localparam logic [8:0] SCP_RB_CTRL_RESET = 9'h000;
  localparam int         SCP_RB_EN_BIT     = 4;
  localparam int         SCP_RB_CONT_BIT   = 3;
  localparam int         SCP_RB_SEL_LSB    = 0;
  localparam int         SCP_STATUS_COUNT  = 7;
  localparam logic [6:0] SCP_STATUS_BASE   = 7'h36;
  localparam logic [5:0] SCP_BUS_ADDR_BASE = 6'h0D;
  localparam logic [4:0] SCP_WORD_BITS     = 5'h10;
  localparam logic [4:0] SCP_ADDR_PHASE    = 5'h08;
  localparam logic [2:0] SCP_LAST_BIT      = 3'h7;
  localparam logic [1:0] SCP_LAST_BYTE     = 2'h2;
  // synchroniser lanes
  localparam int         SCP_LN_SCLK = 0;
  localparam int         SCP_LN_SDA  = 1;
  localparam int         SCP_LN_CS   = 2;
  localparam int         SCP_LN_HW   = 3;
  localparam int         SCP_LN_CFG  = 4;
  localparam int         SCP_LANES   = 5;

  typedef enum logic [3:0] {
    SCP_TW_IDLE  = 4'b0001,
    SCP_TW_SHIFT = 4'b0010,
    SCP_TW_ACK   = 4'b0100,
    SCP_TW_HOLD  = 4'b1000
  } scp_tw_e;

endpackage : scp_pkg

// [design/scp_serial_port.sv]
// serial control port: three-wire and two-wire register writes with readback
module scp_serial_port
  import scp_pkg::*;
#(
  parameter logic [7:0] ID_BYTE0 = 8'h5A,  // arbitrary identification value
  parameter logic [7:0] ID_BYTE1 = 8'hA5,  // arbitrary identification value
  parameter logic [7:0] ID_BYTE2 = 8'h01   // arbitrary identification value
) (
  // system
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // link pins
  input  wire logic                   serialClock,
  input  wire logic                   serialDataInput,
  output logic                        serialDataOut,
  output logic                        serialDataOe,
  input  wire logic                   chipSelectLatchN,
  output logic                        readbackOutput,
  output logic                        readbackOutputOe,
  // straps
  input  wire logic                   pinControlStrap,
  input  wire logic                   serialConfigStrap,
  // status from the device core
  input  wire logic [SCP_STATUS_COUNT-1:0][7:0] statusBytes,
  // register write strobe to the device core
  output logic                        regWrStrobe,
  output logic [6:0]                  regWrAddr,
  output logic [8:0]                  regWrData,
  output logic                        softResetPulse,
  output logic [8:0]                  readbackCtrl,
  output logic                        hardwareMode
);

  // link clock domain: the three-wire shifter
  typedef struct packed {
    logic [15:0] shift;
  } scp_link_s;

  typedef struct packed {
    logic [SCP_LANES-1:0] meta;
    logic [SCP_LANES-1:0] sync;
    logic [SCP_LANES-1:0] last;
    scp_tw_e              tw;
    logic [1:0]           byteIdx;
    logic [7:0]           rxByte;
    logic [6:0]           regAddr;
    logic                 dataMsb;
    logic                 sdaOe;
    logic [4:0]           riseCnt;
    logic [7:0]           addrByte;
    logic [8:0]           rbCtrl;
    logic [7:0]           rbShift;
    logic                 readback_output;
    logic                 sdoOe;
    logic                 wrStrobe;
    logic [6:0]           wrAddr;
    logic [8:0]           wrData;
    logic                 swReset;
    logic                 pin_control_strap;
  } scp_core_s;

  scp_link_s link_reg;
  scp_link_s link_next;
  scp_core_s core_reg;
  scp_core_s core_next;

  always_comb begin
    link_next       = link_reg;
    link_next.shift = {link_reg.shift[14:0], serialDataInput};
  end

  always_ff @(posedge serialClock or negedge rst_n) begin
    if (!rst_n) begin
      link_reg <= '0;
    end else begin
      link_reg <= link_next;
    end
  end

  // readable byte for an address, or the selected status byte
  function automatic logic [7:0] rb_byte(input logic [8:0] ctrl,
                                         input logic [6:0] addr,
                                         input logic [SCP_STATUS_COUNT-1:0][7:0] st);
    logic [2:0] sel;
    logic [6:0] off;
    sel = ctrl[SCP_RB_SEL_LSB+:3];
    off = addr - SCP_STATUS_BASE;
    rb_byte = 8'h00;
    if (ctrl[SCP_RB_CONT_BIT]) begin
      if (sel < 3'(SCP_STATUS_COUNT)) begin
        rb_byte = st[sel];
      end
    end else begin
      case (addr)
        7'h00:   rb_byte = ID_BYTE0;
        7'h01:   rb_byte = ID_BYTE1;
        7'h02:   rb_byte = ID_BYTE2;
        default: begin
          if (addr >= SCP_STATUS_BASE && off < 7'(SCP_STATUS_COUNT)) begin
            rb_byte = st[off[2:0]];
          end
        end
      endcase
    end
  endfunction : rb_byte

  logic       scl;
  logic       sda;
  logic       csN;
  logic       sclRise;
  logic       sclFall;
  logic       startCond;
  logic       stopCond;
  logic       csRise;
  logic       csFall;
  logic       swCtrl;
  logic       threeWire;
  logic       rbEn;
  logic       commit;
  logic [6:0] cAddr;
  logic [8:0] cData;
  logic       load;
  logic [6:0] lAddr;
  logic       shiftOut;
  logic [7:0] busAddr;

  always_comb begin
    core_next = core_reg;
    scl       = core_reg.sync[SCP_LN_SCLK];
    sda       = core_reg.sync[SCP_LN_SDA];
    csN       = core_reg.sync[SCP_LN_CS];
    sclRise   = scl & ~core_reg.last[SCP_LN_SCLK];
    sclFall   = ~scl & core_reg.last[SCP_LN_SCLK];
    startCond = scl & core_reg.last[SCP_LN_SCLK] & ~sda & core_reg.last[SCP_LN_SDA];
    stopCond  = scl & core_reg.last[SCP_LN_SCLK] & sda & ~core_reg.last[SCP_LN_SDA];
    csRise    = csN & ~core_reg.last[SCP_LN_CS];
    csFall    = ~csN & core_reg.last[SCP_LN_CS];
    swCtrl    = ~core_reg.sync[SCP_LN_HW];
    threeWire = core_reg.sync[SCP_LN_CFG];
    rbEn      = core_reg.rbCtrl[SCP_RB_EN_BIT];
    busAddr   = {SCP_BUS_ADDR_BASE, csN, 1'b0};
    commit    = 1'b0;
    cAddr     = 7'h00;
    cData     = 9'h000;
    load      = 1'b0;
    lAddr     = 7'h00;
    shiftOut  = 1'b0;

    // pins pass two flops before the core logic; the link shifter takes the data pin directly
    core_next.meta = {serialConfigStrap, pinControlStrap, chipSelectLatchN,
                      serialDataInput, serialClock};
    core_next.sync = core_reg.meta;
    core_next.last = core_reg.sync;
    core_next.pin_control_strap   = ~swCtrl;
    core_next.wrStrobe = 1'b0;
    core_next.swReset  = 1'b0;

    if (swCtrl && threeWire) begin
      core_next.tw    = SCP_TW_IDLE;
      core_next.sdaOe = 1'b0;
      if (csFall) begin
        core_next.riseCnt = 5'h00;
      end else if (sclRise && !csN) begin
        if (core_reg.riseCnt < SCP_WORD_BITS) begin
          core_next.riseCnt = core_reg.riseCnt + 5'h01;
        end
        if (core_reg.riseCnt < SCP_ADDR_PHASE) begin
          core_next.addrByte = {core_reg.addrByte[6:0], sda};
        end
      end
      if (sclFall && !csN) begin
        if (core_reg.riseCnt == SCP_ADDR_PHASE) begin
          load  = 1'b1;
          lAddr = core_reg.addrByte[7:1];
        end else if (core_reg.riseCnt > SCP_ADDR_PHASE) begin
          shiftOut = 1'b1;
        end
      end
      if (csRise) begin
        // shifter is quiet once the clock stops ahead of the latch edge
        commit = 1'b1;
        cAddr  = link_reg.shift[15:9];
        cData  = link_reg.shift[8:0];
      end
    end else if (swCtrl) begin
      case (core_reg.tw)
        SCP_TW_IDLE: begin
          core_next.sdaOe = 1'b0;
          if (startCond) begin
            core_next.tw      = SCP_TW_SHIFT;
            core_next.byteIdx = 2'h0;
            core_next.riseCnt = 5'h00;
          end
        end
        SCP_TW_SHIFT: begin
          if (sclRise) begin
            core_next.rxByte = {core_reg.rxByte[6:0], sda};
            core_next.riseCnt = core_reg.riseCnt + 5'h01;
          end
          if (sclFall && core_reg.byteIdx == SCP_LAST_BYTE) begin
            shiftOut = 1'b1;
          end
          // rises are counted so the fall right after a start is no byte end
          if (sclFall && core_reg.riseCnt == SCP_ADDR_PHASE) begin
            if (core_reg.byteIdx == 2'h0 && core_reg.rxByte[7:1] != busAddr[7:1]) begin
              core_next.tw = SCP_TW_IDLE;
            end else begin
              core_next.tw    = SCP_TW_ACK;
              core_next.sdaOe = 1'b1;
            end
          end
        end
        SCP_TW_ACK: begin
          if (sclFall) begin
            core_next.sdaOe   = 1'b0;
            core_next.riseCnt = 5'h00;
            case (core_reg.byteIdx)
              2'h0: begin
                core_next.byteIdx = 2'h1;
                core_next.tw      = SCP_TW_SHIFT;
              end
              2'h1: begin
                core_next.regAddr = core_reg.rxByte[7:1];
                core_next.dataMsb = core_reg.rxByte[0];
                core_next.byteIdx = 2'h2;
                core_next.tw      = SCP_TW_SHIFT;
                load  = 1'b1;
                lAddr = core_reg.rxByte[7:1];
              end
              default: begin
                commit = 1'b1;
                cAddr  = core_reg.regAddr;
                cData  = {core_reg.dataMsb, core_reg.rxByte};
                core_next.tw = SCP_TW_HOLD;
              end
            endcase
          end
        end
        SCP_TW_HOLD: begin
          core_next.sdaOe = 1'b0;
        end
        default: begin
          core_next.tw = SCP_TW_IDLE;
        end
      endcase
      if (core_reg.tw != SCP_TW_IDLE && (startCond || stopCond)) begin
        core_next.tw    = SCP_TW_IDLE;
        core_next.sdaOe = 1'b0;
        core_next.sdoOe = 1'b0;
      end
    end else begin
      core_next.tw    = SCP_TW_IDLE;
      core_next.sdaOe = 1'b0;
    end

    if (load) begin
      core_next.rbShift = rb_byte(core_reg.rbCtrl, lAddr, statusBytes);
      core_next.readback_output     = core_next.rbShift[7];
      core_next.sdoOe   = rbEn;
    end else if (shiftOut) begin
      core_next.rbShift = {core_reg.rbShift[6:0], 1'b0};
      core_next.readback_output     = core_reg.rbShift[6];
    end
    if (!swCtrl || !rbEn || (threeWire && csN)) begin
      core_next.sdoOe = 1'b0;
    end
    if (!threeWire && core_reg.tw == SCP_TW_IDLE) begin
      core_next.sdoOe = 1'b0;
    end

    if (commit) begin
      core_next.wrStrobe = 1'b1;
      core_next.wrAddr   = cAddr;
      core_next.wrData   = cData;
      if (cAddr == SCP_RB_CTRL_ADDR) begin
        core_next.rbCtrl = cData;
        core_next.sdoOe  = core_next.sdoOe & cData[SCP_RB_EN_BIT];
      end
      if (cAddr == SCP_SW_RESET_ADDR) begin
        core_next.rbCtrl  = SCP_RB_CTRL_RESET;
        core_next.swReset = 1'b1;
        core_next.sdoOe   = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_reg        <= '0;
      core_reg.tw     <= SCP_TW_IDLE;
      core_reg.rbCtrl <= SCP_RB_CTRL_RESET;
      // chip-select idles high: no false latch edge after reset
      core_reg.meta[SCP_LN_CS] <= 1'b1;
      core_reg.sync[SCP_LN_CS] <= 1'b1;
      core_reg.last[SCP_LN_CS] <= 1'b1;
    end else begin
      core_reg <= core_next;
    end
  end

  assign serialDataOut    = 1'b0;
  assign serialDataOe     = core_reg.sdaOe;
  assign readbackOutput   = core_reg.readback_output;
  assign readbackOutputOe = core_reg.sdoOe;
  assign regWrStrobe      = core_reg.wrStrobe;
  assign regWrAddr        = core_reg.wrAddr;
  assign regWrData        = core_reg.wrData;
  assign softResetPulse   = core_reg.swReset;
  assign readbackCtrl     = core_reg.rbCtrl;
  assign hardwareMode     = core_reg.pin_control_strap;

endmodule : scp_serial_port

// [tb/scp_serial_port_assertions.sv]
// checker bound to the serial control port
module scp_chk
  import scp_pkg::*;
(
  // clock and reset
  input logic       clk,
  input logic       rst_n,
  // pins and straps
  input logic       chipSelectLatchN,
  input logic       serialConfigStrap,
  input logic       serialDataOe,
  input logic       readbackOutputOe,
  // core side
  input logic       regWrStrobe,
  input logic [6:0] regWrAddr,
  input logic [8:0] regWrData,
  input logic       softResetPulse,
  input logic [8:0] readbackCtrl,
  input logic       hardwareMode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence csIdle; chipSelectLatchN [*6]; endsequence
  sequence ctrlWr; regWrStrobe && regWrAddr == SCP_RB_CTRL_ADDR; endsequence
  sequence rstWr; regWrStrobe && regWrAddr == SCP_SW_RESET_ADDR; endsequence
  property ctrlTakes;
    ctrlWr |-> readbackCtrl == regWrData;
  endproperty
  chk_ctrl_takes:
    assert property (ctrlTakes) else $error("control not written");
  chk_soft_clears:
    assert property (rstWr |-> ##[0:1] softResetPulse ##[0:1] readbackCtrl == 9'h000)
    else $error("soft reset failed");
  chk_ctrl_holds:
    assert property ($changed(readbackCtrl) |-> regWrStrobe || $past(regWrStrobe))
    else $error("control changed alone");
  chk_oe_needs_en:
    assert property (readbackOutputOe |-> readbackCtrl[SCP_RB_EN_BIT])
    else $error("readback driven while off");
  chk_hw_quiet:
    assert property (hardwareMode |-> !regWrStrobe && !readbackOutputOe && !serialDataOe)
    else $error("port active in pin control");
  chk_strobe_single:
    assert property (regWrStrobe |=> !regWrStrobe) else $error("strobe too long");
  chk_spi_no_ack:
    assert property (serialConfigStrap [*4] |-> !serialDataOe) else $error("ack in 3-wire");
  chk_cs_floats:
    assert property ((serialConfigStrap throughout csIdle) |-> !readbackOutputOe)
    else $error("readback driven with cs high");
endmodule : scp_chk

bind scp_serial_port scp_chk scp_chk_i (
  .clk(clk), .rst_n(rst_n), .chipSelectLatchN(chipSelectLatchN),
  .serialConfigStrap(serialConfigStrap), .serialDataOe(serialDataOe),
  .readbackOutputOe(readbackOutputOe), .regWrStrobe(regWrStrobe), .regWrAddr(regWrAddr),
  .regWrData(regWrData), .softResetPulse(softResetPulse), .readbackCtrl(readbackCtrl),
  .hardwareMode(hardwareMode)
);

// [tb/scp_host.sv]
// host model driving the control pins on its own time base
module scp_host (
  // serial pins
  output logic      sclk,
  output logic      dat,
  output logic      csN,
  // pins seen
  input  wire logic line,
  input  wire logic rbOut,
  input  wire logic rbOe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       tk = 1'b0;
  logic       low;
  logic       oeSeen;
  logic [7:0] rb;
  int         acks;
  initial begin
    sclk = 1'b0;
    dat = 1'b1;
    csN = 1'b1;
    #1.7;
    forever #3 tk = ~tk;
  end
  // 48 ns halves: the core oversamples the serial clock
  task automatic half;
    repeat (8) @(posedge tk);
  endtask : half
  task automatic bitOut(input logic b, input logic keep);
    @(posedge tk);
    dat = b;
    half();
    sclk = 1'b1;
    low = !line;
    if (keep) begin
      rb = {rb[6:0], rbOut};
      oeSeen = oeSeen | rbOe;
    end
    half();
    sclk = 1'b0;
  endtask : bitOut
  task automatic spi(input logic [15:0] w, input logic pulse);
    rb = 8'h00;
    oeSeen = 1'b0;
    sclk = 1'b0;
    csN = pulse;
    half();
    for (int i = 15; i >= 0; i--) bitOut(w[i], i < 8);
    half();
    csN = 1'b0;
    half();
    csN = 1'b1;
    dat = ~dat;
    repeat (30) @(posedge tk);
  endtask : spi
  task automatic tw(input logic [6:0] dev, input logic [15:0] w, input int stopAt);
    logic [26:0] s;
    s = {dev, 1'b0, 1'b1, w[15:8], 1'b1, w[7:0], 1'b1};
    rb = 8'h00;
    oeSeen = 1'b0;
    acks = 0;
    dat = 1'b1;
    sclk = 1'b1;
    half();
    dat = 1'b0;
    half();
    sclk = 1'b0;
    for (int i = 26; i >= 0 && 26 - i < stopAt; i--) begin
      bitOut(s[i], i < 9 && i > 0);
      if (i % 9 == 0) acks += int'(low);
    end
    @(posedge tk);
    dat = 1'b0;
    half();
    sclk = 1'b1;
    half();
    dat = 1'b1;
    half();
  endtask : tw
endmodule : scp_host

// [tb/scp_serial_port_bench.sv]
// self-checking bench for the serial control port
module scp_serial_port_bench;
  import scp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] ID0 = 8'hC3;  // arbitrary value
  localparam logic [6:0] ADDRS [3] = '{7'h00, 7'h38, 7'h12};
  logic clk = 1'b0, rst_n = 1'b0, hwStrap = 1'b0, cfgStrap = 1'b1, pulse = 1'b0;
  logic sclk, dat, csN, line, sdOe, sdOut, rbOut, rbOe, wrStb, softPls, pin_control_strap;
  logic [6:0] wrAddr;
  logic [8:0] wrData, rbCtrl;
  logic [SCP_STATUS_COUNT-1:0][7:0] stat = 56'h0;
  int failures = 0, n_checks = 0, seed = 42, stbs = 0, softs = 0;
  assign line = dat & !(sdOe & !sdOut);  // open drain with pull-up on the shared data line
  scp_serial_port #(.ID_BYTE0(ID0)) scp_serial_port_i (
    .clk(clk), .rst_n(rst_n), .serialClock(sclk), .serialDataInput(line),
    .serialDataOut(sdOut), .serialDataOe(sdOe), .chipSelectLatchN(csN), .readbackOutput(rbOut),
    .readbackOutputOe(rbOe), .pinControlStrap(hwStrap), .serialConfigStrap(cfgStrap),
    .statusBytes(stat), .regWrStrobe(wrStb), .regWrAddr(wrAddr), .regWrData(wrData),
    .softResetPulse(softPls), .readbackCtrl(rbCtrl), .hardwareMode(pin_control_strap)
  );
  scp_host scp_host_i (.sclk(sclk), .dat(dat), .csN(csN), .line(line), .rbOut(rbOut),
    .rbOe(rbOe));
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (wrStb === 1'b1) stbs++;
    if (softPls === 1'b1) softs++;
  end
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [7:0] expRb(input logic [6:0] a);
    if (a == 7'h00) return ID0;
    if (a >= 7'h36 && a <= 7'h3C) return stat[a - 7'h36];
    return 8'h00;
  endfunction : expRb
  task automatic wr(input logic [6:0] a, input logic [8:0] d);
    int s0;
    s0 = stbs;
    if (cfgStrap) scp_host_i.spi({a, d}, pulse);
    else begin
      scp_host_i.csN = pulse;
      scp_host_i.tw(7'h1A | {6'h00, pulse}, {a, d}, 27);
      check(9'(scp_host_i.acks), hwStrap ? 9'h000 : 9'h003);
    end
    repeat (10) @(posedge clk);
    check(9'(stbs - s0), {8'h00, !hwStrap});
    if (!hwStrap) check({wrAddr, 2'b00}, {a, 2'b00});
    if (!hwStrap) check(wrData, d);
    if (a == 7'h34) check(rbCtrl, d);
    if (a == 7'h35) check(rbCtrl, 9'h000);
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    wr(a, 9'h0AA);
    wr(a, 9'h0AA);
    check({8'h00, scp_host_i.oeSeen}, {8'h00, rbCtrl[4]});
    if (rbCtrl[4]) check({1'b0, scp_host_i.rb}, {1'b0, e});
  endtask : rd
  task automatic final_report;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  initial begin
    #500us;
    failures++;
    final_report();
  end
  initial begin
    int s0;
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (5) @(posedge clk);
    check(rbCtrl, 9'h000);
    check({8'h00, pin_control_strap}, 9'h000);
    for (int m = 0; m < 2; m++) begin
      #1 cfgStrap = (m == 0);
      stat = 56'({$random(seed), $random(seed)});
      repeat (5) @(posedge clk);
      repeat (4) begin
        pulse = 1'($random(seed));
        wr(7'($random(seed)) & 7'h1F, 9'($random(seed)));
      end
      pulse = 1'b0;
      for (int s = 0; s < 7; s++) begin
        wr(7'h34, 9'h018 | 9'(s));
        rd(7'h20, stat[s]);
      end
      wr(7'h34, 9'h010);
      foreach (ADDRS[i]) rd(ADDRS[i], expRb(ADDRS[i]));
      if (m == 0) begin
        wr(7'h34, 9'h008);
        rd(7'h20, 8'h00);
        wr(7'h35, 9'($random(seed)));
        check(9'(softs), 9'h001);
      end else begin
        s0 = stbs;
        scp_host_i.tw(7'h1C, 16'h1234, 27);
        check(9'(scp_host_i.acks), 9'h000);
        scp_host_i.tw(7'h1A, 16'h1234, 14);
        check(9'(scp_host_i.acks), 9'h001);
        repeat (10) @(posedge clk);
        check(9'(stbs - s0), 9'h000);
      end
    end
    #1 hwStrap = 1'b1;
    repeat (5) @(posedge clk);
    check({8'h00, pin_control_strap}, 9'h001);
    wr(7'h11, 9'h155);
    final_report();
  end
endmodule : scp_serial_port_bench
